// ### pmi_regs.svh
/*
 * Constants of the serial register port: bus address, register map
 * offsets used by the port logic, reset values and field positions.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef PMI_REGS_SVH
`define PMI_REGS_SVH

// ****************************************************************
// Bus
// ****************************************************************
`define PMI_TARGET_ADDR   7'h60
`define PMI_CLK_NS        10
`define PMI_SCL_MAX_KHZ   3400
`define PMI_SCL_MIN_CYC   ((1000000 / `PMI_SCL_MAX_KHZ) / `PMI_CLK_NS)

// ****************************************************************
// Register file and byte bit counts
// ****************************************************************
`define PMI_IDX_LAST      8'hFF
`define PMI_OTP_DEFAULT   8'h00
`define PMI_BUCK0_CTRL    8'h02
`define PMI_BUCK1_CTRL    8'h04
`define PMI_LDO0_CTRL     8'h08
`define PMI_LDO1_CTRL     8'h09
`define PMI_EN_BIT        0
`define PMI_BIT_LAST      4'h7
`define PMI_BIT_ACK       4'h8

`endif

// ### pmi_pkg.sv
/*
 * Types of the serial register port: operating modes and the byte
 * engine states. Assumes nothing of its surroundings.
 */
package pmi_pkg;

    typedef enum logic [3:0] {
        MODE_SHUT  = 4'h1,
        MODE_LOAD  = 4'h2,
        MODE_STBY  = 4'h4,
        MODE_ACT   = 4'h8
    } pmi_mode_e;

    typedef enum logic [7:0] {
        ST_IDLE    = 8'h01,
        ST_ADDR    = 8'h02,
        ST_REG     = 8'h04,
        ST_WDATA   = 8'h08,
        ST_RDATA   = 8'h10,
        ST_MACK    = 8'h20,
        ST_IGNORE  = 8'h40,
        ST_SPARE   = 8'h80
    } pmi_state_e;

endpackage

// ### pmi_line_if.sv
/*
 * Carrier between the line monitor and the byte engine: synchronised
 * levels and one-cycle bus events. Assumes a single clk_sys domain.
 */
`timescale 1ns/1ns
interface pmi_line_if;
    logic scl_s;
    logic sda_s;
    logic sup_s;
    logic scl_rise;
    logic scl_fall;
    logic start;
    logic stop;

    modport mon (output scl_s, sda_s, sup_s, scl_rise, scl_fall, start,
                 stop);
    modport eng (input scl_s, sda_s, sup_s, scl_rise, scl_fall, start,
                 stop);
endinterface

// ### pmi_line_mon.sv
/*
 * Line monitor: brings the bus clock, bus data and supply comparator
 * into clk_sys and finds clock edges and start/stop conditions.
 * Assumes asynchronous inputs from pins.
 */
`timescale 1ns/1ns
module pmi_line_mon (
    input  wire logic clk_sys,    // System clock
    input  wire logic srst,       // Synchronous reset
    input  wire logic scl_pin,    // Bus clock pin
    input  wire logic sda_pin_in, // Bus data pin level
    input  wire logic sup_pin,    // Supply above lockout
    pmi_line_if.mon   line        // Events to the engine
);
    logic [2:0] raw;
    logic [2:0] sync1_r;
    logic [2:0] sync2_r;
    logic       scl_d_r;
    logic       sda_d_r;

    assign raw = {sup_pin, sda_pin_in, scl_pin};

    // ************************************************************
    // Two-stage synchronisers
    // ************************************************************
    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : gen_sync
            always_ff @(posedge clk_sys) begin
                if (srst) begin
                    sync1_r[g] <= 1'b1;
                    sync2_r[g] <= 1'b1;
                end else begin
                    sync1_r[g] <= raw[g];
                    sync2_r[g] <= sync1_r[g];
                end
            end
        end
    endgenerate

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
        end else begin
            scl_d_r <= sync2_r[0];
            sda_d_r <= sync2_r[1];
        end
    end

    assign line.scl_s    = sync2_r[0];
    assign line.sda_s    = sync2_r[1];
    assign line.sup_s    = sync2_r[2];
    assign line.scl_rise = !scl_d_r && sync2_r[0];
    assign line.scl_fall = scl_d_r && !sync2_r[0];
    // Data edge with clock high on both samples
    assign line.start = scl_d_r && sync2_r[0] && sda_d_r && !sync2_r[1];
    assign line.stop  = scl_d_r && sync2_r[0] && !sda_d_r && sync2_r[1];
endmodule

// ### pmi_port.sv
/*
 * Serial register port of the power device: byte engine, register
 * file, fuse load and operating mode.
 * Assumes asynchronous bus pins with external pull-ups and a supply
 * comparator level; all logic runs on clk_sys.
 */
// How it works
// - Runs at 100 kHz to 3.4 MHz bus clocks by oversampling at 100 MHz.
// - Data changes only while clock low; held while clock high.
// - Data falling while clock high marks start of transfer.
// - Data rising while clock high marks end of transfer.
// - Bus busy from start until stop, free after.
// - Repeated start restarts address reception like a start.
// - Bytes are eight bits, MSB first, then one acknowledge slot.
// - Port pulls data low in the ninth pulse after each byte received, except in a transfer whose address byte is refused.
// - Below supply lockout the port never drives data.
// - First byte: seven-bit address then direction, 0 write, 1 read.
// - Write: byte after address picks register, next byte stored.
// - Standby and active allow reading and writing every register.
// - Above lockout: fuse load, regulators off, defaults copied in.
// - Active when any regulator enabled, standby when none.
// - Index advances after each written byte; reads do not advance.
`timescale 1ns/1ns
`include "pmi_regs.svh"
module pmi_port (
    input  wire logic       clk_sys,                   // 100 MHz clock
    input  wire logic       srst,                      // Sync reset
    input  wire logic       scl_pin,                   // Bus clock
    input  wire logic       sda_pin_in,                // Bus data in
    output logic            sda_pin_out,               // Bus data out
    output logic            sda_pin_oe,                // Data drive
    input  wire logic       main_supply_above_lockout, // Supply good
    output logic [3:0]      op_mode,                   // Mode, one-hot
    output logic [3:0]      reg_enable                 // Regulators on
);
    pmi_line_if line ();

    pmi_pkg::pmi_state_e state_r;
    pmi_pkg::pmi_mode_e  mode_r;
    logic [7:0] regs [256];
    logic [3:0] cnt_r;
    logic [7:0] shift_r;
    logic [7:0] tx_r;
    logic [7:0] idx_r;
    logic [7:0] load_idx_r;
    logic       ack_r;
    logic       rw_r;
    logic       nack_r;
    logic       oe_r;
    logic       wr_stb_r;
    logic [7:0] wr_idx_r;
    logic [7:0] wr_data_r;
    logic [3:0] en_bits;
    logic       any_en;
    logic       access_ok;

    localparam logic [7:0] EN_REG [4] = '{`PMI_BUCK0_CTRL, `PMI_BUCK1_CTRL,
                                          `PMI_LDO0_CTRL, `PMI_LDO1_CTRL};

    // Oversampling: fastest clock high time spans several samples
    pmi_line_mon u_mon (
        .clk_sys    (clk_sys),
        .srst       (srst),
        .scl_pin    (scl_pin),
        .sda_pin_in (sda_pin_in),
        .sup_pin    (main_supply_above_lockout),
        .line       (line.mon)
    );

    function automatic logic [7:0] otp_default(input logic [7:0] idx);
        otp_default = `PMI_OTP_DEFAULT ^ (idx & 8'h00);
    endfunction

    assign access_ok = (mode_r == pmi_pkg::MODE_STBY) ||
                       (mode_r == pmi_pkg::MODE_ACT);

    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : gen_en
            assign en_bits[g] = regs[EN_REG[g]][`PMI_EN_BIT];
        end
    endgenerate
    assign any_en = |en_bits;

    // ************************************************************
    // Byte engine and data line drive
    // ************************************************************
    // Drive only turns on at a seen clock fall, so data is steady high; start, stop and lockout only release it
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            state_r  <= pmi_pkg::ST_IDLE;
            cnt_r    <= 4'h0;
            shift_r  <= 8'h00;
            tx_r     <= 8'h00;
            idx_r    <= 8'h00;
            ack_r    <= 1'b0;
            rw_r     <= 1'b0;
            nack_r   <= 1'b0;
            oe_r     <= 1'b0;
            wr_stb_r <= 1'b0;
            wr_idx_r <= 8'h00;
            wr_data_r <= 8'h00;
        end else begin
            wr_stb_r <= 1'b0;
            if (line.start) begin
                state_r <= pmi_pkg::ST_ADDR;
                cnt_r   <= 4'h0;
                ack_r   <= 1'b0;
                oe_r    <= 1'b0;
            end else if (line.stop) begin
                state_r <= pmi_pkg::ST_IDLE;
                ack_r   <= 1'b0;
                oe_r    <= 1'b0;
            end else begin
                case (state_r)
                    pmi_pkg::ST_ADDR, pmi_pkg::ST_REG,
                    pmi_pkg::ST_WDATA: begin
                        if (!ack_r && line.scl_rise) begin
                            shift_r <= {shift_r[6:0], line.sda_s};
                            cnt_r   <= cnt_r + 4'h1;
                        end else if (!ack_r && line.scl_fall &&
                                     cnt_r == `PMI_BIT_ACK) begin
                            cnt_r <= 4'h0;
                            ack_r <= 1'b1;
                            oe_r  <= 1'b1;
                            if (state_r == pmi_pkg::ST_ADDR) begin
                                rw_r <= shift_r[0];
                                if (shift_r[7:1] != `PMI_TARGET_ADDR ||
                                    !access_ok) begin
                                    state_r <= pmi_pkg::ST_IGNORE;
                                    ack_r   <= 1'b0;
                                    oe_r    <= 1'b0;
                                end
                            end else if (state_r == pmi_pkg::ST_REG) begin
                                idx_r <= shift_r;
                            end else begin
                                wr_stb_r  <= 1'b1;
                                wr_idx_r  <= idx_r;
                                wr_data_r <= shift_r;
                                idx_r     <= idx_r + 8'h01;
                            end
                        end else if (ack_r && line.scl_fall) begin
                            ack_r <= 1'b0;
                            oe_r  <= 1'b0;
                            if (state_r == pmi_pkg::ST_ADDR && rw_r) begin
                                state_r <= pmi_pkg::ST_RDATA;
                                tx_r    <= regs[idx_r];
                                oe_r    <= !regs[idx_r][7];
                            end else if (state_r == pmi_pkg::ST_ADDR) begin
                                state_r <= pmi_pkg::ST_REG;
                            end else begin
                                state_r <= pmi_pkg::ST_WDATA;
                            end
                        end
                    end
                    pmi_pkg::ST_RDATA: begin
                        if (line.scl_fall) begin
                            if (cnt_r == `PMI_BIT_LAST) begin
                                cnt_r   <= 4'h0;
                                oe_r    <= 1'b0;
                                state_r <= pmi_pkg::ST_MACK;
                            end else begin
                                cnt_r <= cnt_r + 4'h1;
                                tx_r  <= {tx_r[6:0], 1'b0};
                                oe_r  <= !tx_r[6];
                            end
                        end
                    end
                    pmi_pkg::ST_MACK: begin
                        if (line.scl_rise) begin
                            nack_r <= line.sda_s;
                        end else if (line.scl_fall) begin
                            if (nack_r) begin
                                state_r <= pmi_pkg::ST_IGNORE;
                            end else begin
                                state_r <= pmi_pkg::ST_RDATA;
                                tx_r    <= regs[idx_r];
                                oe_r    <= !regs[idx_r][7];
                            end
                        end
                    end
                    default: begin
                        ack_r <= 1'b0;
                    end
                endcase
            end
            if (!line.sup_s) begin
                oe_r <= 1'b0;
            end
        end
    end

    // ************************************************************
    // Register file and fuse load
    // ************************************************************
    // Bus writes need standby or active at the address byte; the fuse walk wins a clash
    always_ff @(posedge clk_sys) begin
        if (mode_r == pmi_pkg::MODE_LOAD) begin
            regs[load_idx_r] <= otp_default(load_idx_r);
        end else if (wr_stb_r) begin
            regs[wr_idx_r] <= wr_data_r;
        end
    end

    // ************************************************************
    // Operating mode
    // ************************************************************
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            mode_r     <= pmi_pkg::MODE_SHUT;
            load_idx_r <= 8'h00;
        end else if (!line.sup_s) begin
            mode_r     <= pmi_pkg::MODE_SHUT;
            load_idx_r <= 8'h00;
        end else begin
            case (mode_r)
                pmi_pkg::MODE_SHUT: begin
                    mode_r <= pmi_pkg::MODE_LOAD;
                end
                pmi_pkg::MODE_LOAD: begin
                    load_idx_r <= load_idx_r + 8'h01;
                    if (load_idx_r == `PMI_IDX_LAST) begin
                        mode_r <= pmi_pkg::MODE_STBY;
                    end
                end
                default: begin
                    mode_r <= any_en ? pmi_pkg::MODE_ACT
                                     : pmi_pkg::MODE_STBY;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            reg_enable <= 4'h0;
        end else begin
            reg_enable <= access_ok ? en_bits : 4'h0;
        end
    end

    // Open drain: only ever pulls low
    always_ff @(posedge clk_sys) begin
        sda_pin_out <= 1'b0;
    end
    assign sda_pin_oe = oe_r;
    assign op_mode    = mode_r;

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);

    sequence byte_done_s;
        !ack_r && line.scl_fall && cnt_r == `PMI_BIT_ACK;
    endsequence

    start_addr_a: assert property (line.start |=>
        state_r == pmi_pkg::ST_ADDR && !oe_r)
        else $error("start did not restart address reception");
    stop_idle_a: assert property (line.stop && !line.start |=>
        state_r == pmi_pkg::ST_IDLE)
        else $error("stop did not free the bus");
    lockout_quiet_a: assert property (!line.sup_s |=> !sda_pin_oe)
        else $error("data driven below supply lockout");
    steady_high_a: assert property ($rose(sda_pin_oe) |->
        !line.scl_s)
        else $error("data drive began with clock high");
    reg_ack_a: assert property (byte_done_s and
        (state_r == pmi_pkg::ST_REG) && line.sup_s
        |=> sda_pin_oe && ack_r)
        else $error("received byte not acknowledged");
    addr_miss_a: assert property (byte_done_s and
        (state_r == pmi_pkg::ST_ADDR) &&
        shift_r[7:1] != `PMI_TARGET_ADDR
        |=> state_r == pmi_pkg::ST_IGNORE && !sda_pin_oe)
        else $error("foreign address acknowledged");
    write_step_a: assert property (wr_stb_r |->
        idx_r == wr_idx_r + 8'h01)
        else $error("index did not advance after write");
    fuse_off_a: assert property (mode_r == pmi_pkg::MODE_LOAD |->
        reg_enable == 4'h0 ##1 reg_enable == 4'h0)
        else $error("regulator on during fuse load");
    bit_count_a: assert property (cnt_r <= `PMI_BIT_ACK)
        else $error("bit count past acknowledge slot");
    mode_track_a: assert property (access_ok && line.sup_s &&
        $stable(any_en) ##1 access_ok && line.sup_s
        |=> mode_r == ($past(any_en) ? pmi_pkg::MODE_ACT
                                     : pmi_pkg::MODE_STBY))
        else $error("active or standby does not follow enables");
endmodule

// ### pmi_ctl_model.sv
/*
 * Bus controller model: makes the bus clock and drives the data line
 * open-drain from tasks called by the bench.
 * Assumes the bench resolves the data wire with a pull-up.
 */
`timescale 1ns/1ns
module pmi_ctl_model (
    output logic      scl,     // Bus clock, stands high outside frames
    output logic      sda_drv, // Data drive, 1 = released
    input  wire logic sda_bus  // Resolved data wire
);
    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end

    // ****************************************************************
    // Bit slot: 62 ns low, 63 ns high, sampled late in the high phase
    // ****************************************************************
    task automatic bit_io(input logic b, output logic r);
        #20 sda_drv = b;
        #42 scl = 1'b1;
        #60 r = sda_bus;
        #3 scl = 1'b0;
    endtask

    // Start or repeated start; only this side frames the bus
    task automatic start();
        if (scl === 1'b0) begin
            #20 sda_drv = 1'b1;
            #42 scl = 1'b1;
        end
        #31 sda_drv = 1'b0;
        #32 scl = 1'b0;
    endtask

    task automatic stop();
        #20 sda_drv = 1'b0;
        #42 scl = 1'b1;
        #31 sda_drv = 1'b1;
        #32;
    endtask

    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic x;
        for (int i = 7; i >= 0; i--) bit_io(d[i], x);
        bit_io(1'b1, ack);
    endtask

    task automatic rbyte(input logic last, output logic [7:0] d);
        logic x;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, x);
            d[i] = x;
        end
        bit_io(last, x);
    endtask
endmodule

// ### pmi_i2c_register_port_tb_top.sv
/*
 * Self-checking bench of the serial register port.
 * Assumes the controller model drives the bus; the bench holds reset,
 * the supply comparator level and the pull-up on the data wire.
 */
`timescale 1ns/1ns
`include "pmi_regs.svh"
module pmi_i2c_register_port_tb_top;
    logic       clk_sys = 1'b0;
    logic       srst = 1'b1;
    logic       sup = 1'b1;
    logic       scl;
    logic       ctl_sda;
    logic       sda_out;
    logic       sda_oe;
    logic [3:0] op_mode;
    logic [3:0] reg_enable;
    logic       lock_drive = 1'b0;
    wire  logic sda_bus;
    int         miscompares = 0;
    int         n_tests = 0;

    assign sda_bus = ctl_sda & (sda_oe ? sda_out : 1'b1);
    always #5 clk_sys = ~clk_sys;

    pmi_port uut (.clk_sys(clk_sys), .srst(srst), .scl_pin(scl),
        .sda_pin_in(sda_bus), .sda_pin_out(sda_out), .sda_pin_oe(sda_oe),
        .main_supply_above_lockout(sup), .op_mode(op_mode),
        .reg_enable(reg_enable));
    pmi_ctl_model ctl (.scl(scl), .sda_drv(ctl_sda), .sda_bus(sda_bus));

    // Sticky: any data drive while the supply is low
    always @(posedge clk_sys) begin
        if (sup === 1'b0 && sda_oe !== 1'b0) lock_drive <= 1'b1;
    end

    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    task automatic complete_run();
        $display("Comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    task automatic chk(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wait_mode(input logic [3:0] m);
        int k;
        for (k = 0; k < 1000 && op_mode !== m; k++) @(posedge clk_sys);
        if (k == 1000) begin
            miscompares++;
            $display("ERROR op_mode expected %h seen %h", m, op_mode);
            complete_run();
        end
    endtask

    task automatic addr_ack(input logic [7:0] a, input logic [7:0] exp);
        logic ack;
        ctl.wbyte(a, ack);
        chk("ack", exp, {7'h00, ack});
    endtask

    task automatic wr(input logic [7:0] r, input logic [7:0] d0,
                      input logic [7:0] d1, input int n);
        ctl.start();
        addr_ack({`PMI_TARGET_ADDR, 1'b0}, 8'h00);
        addr_ack(r, 8'h00);
        addr_ack(d0, 8'h00);
        if (n > 1) addr_ack(d1, 8'h00);
        ctl.stop();
        repeat (10) @(posedge clk_sys);
    endtask

    task automatic rd(input logic [7:0] r, input logic [7:0] exp,
                      input int n);
        logic [7:0] d;
        ctl.start();
        addr_ack({`PMI_TARGET_ADDR, 1'b0}, 8'h00);
        addr_ack(r, 8'h00);
        ctl.start();
        addr_ack({`PMI_TARGET_ADDR, 1'b1}, 8'h00);
        for (int i = 1; i <= n; i++) begin
            ctl.rbyte(i == n, d);
            chk("read data", exp, d);
        end
        ctl.stop();
    endtask

    // Address byte and one more byte, both left unanswered
    task automatic refused(input logic [7:0] a);
        ctl.start();
        addr_ack(a, 8'h01);
        addr_ack(8'h02, 8'h01);
        ctl.stop();
    endtask

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic sc_reset_load();
        repeat (3) @(posedge clk_sys);
        chk("op_mode", 8'h01, {4'h0, op_mode});
        chk("sda_oe", 8'h00, {7'h00, sda_oe});
        @(posedge clk_sys) srst <= 1'b0;
        repeat (6) @(posedge clk_sys);
        chk("op_mode", 8'h02, {4'h0, op_mode});
        refused({`PMI_TARGET_ADDR, 1'b0});
        wait_mode(4'h4);
        chk("reg_enable", 8'h00, {4'h0, reg_enable});
    endtask

    task automatic sc_foreign_addr();
        refused({`PMI_TARGET_ADDR + 7'h01, 1'b0});
        wr(8'h30, 8'h1E, 8'h00, 1);
        rd(8'h30, 8'h1E, 1);
    endtask

    task automatic sc_enables();
        logic [7:0] regs [4] = '{8'h02, 8'h04, 8'h08, 8'h09};
        logic [3:0] exp = 4'h0;
        for (int i = 0; i < 4; i++) begin
            wr(regs[i], 8'h01, 8'h00, 1);
            exp[i] = 1'b1;
            chk("reg_enable", {4'h0, exp}, {4'h0, reg_enable});
            chk("op_mode", 8'h08, {4'h0, op_mode});
            rd(regs[i], 8'h01, 1);
        end
        wr(8'h08, 8'h00, 8'h00, 2);
        wr(8'h02, 8'h00, 8'h00, 1);
        chk("reg_enable", 8'h02, {4'h0, reg_enable});
        wr(8'h04, 8'h00, 8'h00, 1);
        chk("op_mode", 8'h04, {4'h0, op_mode});
    endtask

    task automatic sc_burst_wrap();
        wr(8'hFF, 8'h55, 8'h66, 2);
        rd(8'hFF, 8'h55, 2);
        rd(8'h00, 8'h66, 1);
        wr(8'h40, 8'h5A, 8'hC3, 2);
        rd(8'h41, 8'hC3, 1);
        rd(8'h42, 8'h00, 1);
    endtask

    // Repeated start mid-write starts a fresh transfer
    task automatic sc_restart();
        ctl.start();
        addr_ack({`PMI_TARGET_ADDR, 1'b0}, 8'h00);
        addr_ack(8'h50, 8'h00);
        ctl.start();
        addr_ack({`PMI_TARGET_ADDR, 1'b0}, 8'h00);
        addr_ack(8'h51, 8'h00);
        addr_ack(8'h77, 8'h00);
        ctl.stop();
        rd(8'h51, 8'h77, 1);
        rd(8'h50, 8'h00, 1);
    endtask

    task automatic sc_lockout();
        @(posedge clk_sys) sup <= 1'b0;
        wait_mode(4'h1);
        refused({`PMI_TARGET_ADDR, 1'b0});
        chk("drive in lockout", 8'h00, {7'h00, lock_drive});
        @(posedge clk_sys) sup <= 1'b1;
        wait_mode(4'h2);
        wait_mode(4'h4);
        rd(8'h30, `PMI_OTP_DEFAULT, 1);
    endtask

    initial begin
        sc_reset_load();
        sc_foreign_addr();
        sc_enables();
        sc_burst_wrap();
        sc_restart();
        sc_lockout();
        complete_run();
    end
endmodule
